/* common/twi_cmd_pkg.sv */
package twi_cmd_pkg;
    // addressing and command decode
    localparam logic [3:0] DEV_ADDR_FIXED = 4'hB;
    localparam logic [3:0] OP_WRITE_USER = 4'h0;
    localparam logic [3:0] OP_RANDOM_READ = 4'h1;
    localparam logic [3:0] OP_READ_USER = 4'h2;
    localparam logic [3:0] OP_SYS_WRITE = 4'h4;
    localparam logic [7:0] SYS_CFG = 8'h00;
    localparam logic [7:0] SYS_FUSE = 8'h01;
    localparam logic [7:0] SYS_CHECKSUM = 8'h02;
    localparam logic [7:0] SYS_ZONE = 8'h03;
    localparam logic [7:0] SYS_CFG_AT = 8'h08;
    localparam logic [7:0] SYS_ZONE_AT = 8'h0B;
    ////////////////////////////////////////////////////////////////////////////////
    // fuses: bit positions inside the fuse nibble and their ids
    localparam logic [7:0] FUSE_ID_LOT = 8'h07;
    localparam logic [7:0] FUSE_ID_FAB = 8'h06;
    localparam logic [7:0] FUSE_ID_ISSUER = 8'h04;
    localparam logic [7:0] FUSE_ID_PERS = 8'h00;
    localparam int FUSE_FAB = 0;
    localparam int FUSE_ISSUER = 1;
    localparam int FUSE_PERS = 2;
    localparam int FUSE_LOT = 3;
    localparam logic [3:0] FUSE_RESET = 4'h7;
    ////////////////////////////////////////////////////////////////////////////////
    // sizes and bit counting
    localparam logic [7:0] PAGE_N = 8'h10;
    localparam int PAGE = 16;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_HOST_ACK = 4'h9;
    localparam logic [8:0] READ_ALL = 9'h100;
    localparam logic [7:0] CFG_HIGH = 8'h00;
    localparam int ENTRY_W = 25;
    localparam int FIFO_DEPTH = 8;
    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS = 1000000;
    localparam int T_WRITE_MS = 5;
    localparam int T_WRITE_AT_MS = 20;
    localparam int TMR_W = 24;

    typedef enum logic [2:0] {
        st_idle, st_cmd, st_a1, st_a2, st_cnt, st_wdat, st_rdat, st_ignore
    } link_state_type;
endpackage : twi_cmd_pkg

/* core/byte_fifo.sv */
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic full_q;
    logic nonempty_q;
    wire push = in_valid && !full_q;
    wire pop = nonempty_q && out_ready;

    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready = !full_q;
    assign out_valid = nonempty_q;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
            nonempty_q <= 1'b0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            full_q <= cnt_d == FULL;
            nonempty_q <= cnt_d != '0;
        end
    end
endmodule : byte_fifo

/* core/twi_cmd_core.sv */
`timescale 1ns/100ps
// Overview of operation
// - high nibble of command byte is device address; nibble B answers whenever not busy.
// - low nibble of device_config_byte is a second answering address, shipped as F.
// - every link byte moves most significant bit first, both directions.
// - user write B0 takes two address bytes, accepts at most 16 data bytes.
// - crypto-mode user write data waits in buffer; checksum bytes overwrite it, good checksum commits them at last direct write's address, bad discards.
// - no write permission means count byte of the write is not acknowledged.
// - aborted write header leaves its address as the read pointer.
// - random read B1 returns pointer byte, increments, continues while host acknowledges.
// - read pointer wraps from zone end back to zone start.
// - read B2 returns count bytes from address, count zero means 256.
// - no read permission means count byte of the read is not acknowledged.
// - system write B4 decodes first_param: config, fuse, checksum, zone select.
// - config write touching unauthorized bytes writes nothing.
// - fuses only go one to zero and need secure code first.
// - fuses blow in order: fab, then issuer, then personalization.
// - crypto-mode zone write starts only after checksum via first_param 02.
// - bad checksum clears the held authentication privilege.
// - zone selection required (not enforced here: user reads and writes run with no zone selected); first_param 0B turns on anti-tearing until next select.
// - config write with first_param 08 uses anti-tearing.
// - commands other than random read carry four header bytes.
// - normal reads drive data right after the count byte.
// - while busy the command byte of a poll is not acknowledged.
module twi_cmd_core
    import twi_cmd_pkg::*;
#(
    parameter int WRITE_CYC = T_WRITE_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int WRITE_AT_CYC = T_WRITE_AT_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] device_config_byte,
    input wire logic zone_wr_allowed,
    input wire logic zone_rd_allowed,
    input wire logic zone_crypto_write,
    input wire logic secure_code_ok,
    input wire logic checksum_ok,
    input wire logic [7:0] cfg_auth_lo,
    input wire logic [7:0] cfg_auth_hi,
    input wire logic [15:0] zone_last,
    output logic [15:0] rd_addr,
    output logic rd_cfg,
    input wire logic [7:0] rd_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [15:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    output logic mem_wr_cfg,
    output logic [7:0] zone_sel,
    output logic anti_tear,
    output logic [3:0] fuse_state,
    output logic [15:0] checksum_word,
    output logic crypto_reset,
    output logic auth_clear,
    output logic busy
);
    function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic cfg,
                                             input logic [15:0] last);
        if (cfg) begin
            next_ptr = {CFG_HIGH, p[7:0] + 8'h01};
        end else if (p == last) begin
            next_ptr = '0;
        end else begin
            next_ptr = p + 16'h0001;
        end
    endfunction : next_ptr

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bus conditions
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_in, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
        end
    end
    wire rise = scl_s_q && !scl_p_q;
    wire fall = !scl_s_q && scl_p_q;
    wire start_ev = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    wire stop_ev = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    link_state_type state_q, nxt;
    logic [3:0] op_q, cnt_q;
    logic [7:0] sh_q, a1_q, a2_q;
    logic [8:0] rem_q;
    logic ackph_q, tx_q, hack_q, oe_q, go_tx_q, random_q;
    logic [15:0] ptr_q, wbase_q, chk_q;
    logic ptr_cfg_q, wcfg_q, pend_q, cp_act_q, busy_q, at_q, zone_at_q;
    logic [4:0] wcount_q, cp_idx_q;
    logic [7:0] wbuf_q [PAGE];
    logic [7:0] zone_q;
    logic [3:0] fuse_q;
    logic [TMR_W-1:0] tmr_q;
    logic crst_q, aclr_q;
    logic ack_ok, start_tx;
    logic fifo_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // byte decode
    wire byte_done = fall && !tx_q && !ackph_q && cnt_q == BIT_LAST;
    wire addr_hit = sh_q[7:4] == DEV_ADDR_FIXED || sh_q[7:4] == device_config_byte[3:0];
    wire is_cfg_wr = a1_q == SYS_CFG || a1_q == SYS_CFG_AT;
    wire is_zone_set = a1_q == SYS_ZONE || a1_q == SYS_ZONE_AT;
    wire sys_known = is_cfg_wr || is_zone_set || a1_q == SYS_FUSE || a1_q == SYS_CHECKSUM;
    wire buf_room = wcount_q < PAGE_N[4:0];
    wire n_fits = sh_q <= PAGE_N;
    wire is_user_wr = op_q == OP_WRITE_USER;
    wire is_sys = op_q == OP_SYS_WRITE;
    wire more = random_q || rem_q != 9'h000;

    always_comb begin
        ack_ok = 1'b0;
        nxt = st_ignore;
        start_tx = 1'b0;
        case (state_q)
            st_cmd: begin
                ack_ok = addr_hit && !busy_q;
                start_tx = ack_ok && sh_q[3:0] == OP_RANDOM_READ;
                if (ack_ok) begin
                    nxt = start_tx ? st_rdat : st_a1;
                end
            end
            st_a1: begin
                ack_ok = 1'b1;
                nxt = st_a2;
            end
            st_a2: begin
                ack_ok = 1'b1;
                nxt = st_cnt;
            end
            st_cnt: begin
                case (op_q)
                    OP_WRITE_USER: begin
                        ack_ok = zone_wr_allowed && n_fits;
                        nxt = ack_ok ? st_wdat : st_ignore;
                    end
                    OP_READ_USER: begin
                        ack_ok = zone_rd_allowed;
                        start_tx = ack_ok;
                        nxt = ack_ok ? st_rdat : st_ignore;
                    end
                    OP_SYS_WRITE: begin
                        ack_ok = sys_known && (!is_cfg_wr || n_fits);
                        nxt = ack_ok ? st_wdat : st_ignore;
                    end
                    default: begin
                        ack_ok = 1'b1;
                    end
                endcase
            end
            st_wdat: begin
                ack_ok = buf_room;
                nxt = st_wdat;
            end
            default: begin
                ack_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bit sequencer: receive on rising scl, drive on falling scl
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= st_idle;
            cnt_q <= '0;
            sh_q <= '0;
            ackph_q <= 1'b0;
            tx_q <= 1'b0;
            oe_q <= 1'b0;
            go_tx_q <= 1'b0;
            hack_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            state_q <= start_ev ? st_cmd : st_idle;
            cnt_q <= '0;
            ackph_q <= 1'b0;
            tx_q <= 1'b0;
            oe_q <= 1'b0;
            go_tx_q <= 1'b0;
        end else if (rise && !tx_q && !ackph_q && cnt_q < BIT_LAST && state_q != st_idle) begin
            sh_q <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
        end else if (byte_done) begin
            oe_q <= ack_ok;
            ackph_q <= 1'b1;
            state_q <= nxt;
            go_tx_q <= start_tx;
        end else if (fall && ackph_q) begin
            ackph_q <= 1'b0;
            tx_q <= go_tx_q;
            sh_q <= rd_data;
            oe_q <= go_tx_q && !rd_data[7];
            cnt_q <= go_tx_q ? 4'h1 : 4'h0;
        end else if (rise && tx_q && cnt_q == BIT_HOST_ACK) begin
            hack_q <= !sda_s_q;
        end else if (fall && tx_q) begin
            if (cnt_q < BIT_LAST) begin
                oe_q <= !sh_q[6];
                sh_q <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
            end else if (cnt_q == BIT_LAST) begin
                oe_q <= 1'b0;
                cnt_q <= BIT_HOST_ACK;
            end else if (hack_q && more) begin
                sh_q <= rd_data;
                oe_q <= !rd_data[7];
                cnt_q <= 4'h1;
            end else begin
                tx_q <= 1'b0;
                state_q <= st_ignore;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // header capture, pointer and write buffer
    wire hdr_ld = byte_done && state_q == st_cnt;
    wire ptr_ld = hdr_ld && (is_user_wr || op_q == OP_READ_USER || (is_sys && is_cfg_wr));
    wire ptr_step = fall && tx_q && cnt_q == BIT_LAST;
    wire wd_take = byte_done && state_q == st_wdat && buf_room;
    wire [15:0] hdr_addr = (is_sys && is_cfg_wr) ? {CFG_HIGH, a2_q} : {a1_q, a2_q};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            op_q <= '0;
            a1_q <= '0;
            a2_q <= '0;
            random_q <= 1'b0;
        end else if (byte_done) begin
            if (state_q == st_cmd) begin
                op_q <= sh_q[3:0];
                random_q <= sh_q[3:0] == OP_RANDOM_READ;
            end
            if (state_q == st_a1) begin
                a1_q <= sh_q;
            end
            if (state_q == st_a2) begin
                a2_q <= sh_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= '0;
            ptr_cfg_q <= 1'b0;
            rem_q <= '0;
        end else if (ptr_ld) begin
            ptr_q <= hdr_addr;
            ptr_cfg_q <= is_sys;
            rem_q <= (sh_q == 8'h00) ? READ_ALL : {1'b0, sh_q};
        end else if (ptr_step) begin
            ptr_q <= next_ptr(ptr_q, ptr_cfg_q, zone_last);
            rem_q <= rem_q - 9'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (wd_take) begin
            wbuf_q[wcount_q[3:0]] <= sh_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wcount_q <= '0;
            chk_q <= '0;
        end else if (hdr_ld) begin
            wcount_q <= '0;
        end else if (wd_take) begin
            wcount_q <= wcount_q + 5'h01;
            if (is_sys && a1_q == SYS_CHECKSUM) begin
                chk_q <= {chk_q[7:0], sh_q};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // execution at Stop
    wire exec = stop_ev && state_q == st_wdat;
    wire has_data = wcount_q != 5'h00;
    wire [8:0] cfg_end = {1'b0, a2_q} + {4'h0, wcount_q} - 9'h001;
    wire cfg_ok = a2_q >= cfg_auth_lo && cfg_end <= {1'b0, cfg_auth_hi};
    wire chk_exec = exec && is_sys && a1_q == SYS_CHECKSUM;
    wire chk_bad = chk_exec && !checksum_ok;
    wire chk_commit = chk_exec && pend_q && checksum_ok;
    wire hold = exec && is_user_wr && zone_crypto_write && has_data;
    wire direct_commit = exec && has_data &&
        ((is_user_wr && !zone_crypto_write) || (is_sys && is_cfg_wr && cfg_ok));
    wire do_commit = direct_commit || chk_commit;
    wire fuse_exec = exec && is_sys && a1_q == SYS_FUSE;
    wire fuse_order = a2_q == FUSE_ID_LOT || a2_q == FUSE_ID_FAB ||
        (a2_q == FUSE_ID_ISSUER && !fuse_q[FUSE_FAB]) ||
        (a2_q == FUSE_ID_PERS && !fuse_q[FUSE_ISSUER]);
    wire fuse_go = fuse_exec && secure_code_ok && fuse_order;
    wire zone_exec = exec && is_sys && is_zone_set;
    wire busy_go = do_commit || fuse_exec || chk_exec;
    wire at_sel = (is_sys && is_cfg_wr) ? a1_q == SYS_CFG_AT : zone_at_q;
    wire cp_last = cp_idx_q == wcount_q - 5'h01;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend_q <= 1'b0;
            crst_q <= 1'b0;
            aclr_q <= 1'b0;
        end else begin
            pend_q <= hold || (pend_q && !chk_exec);
            crst_q <= chk_bad && pend_q;
            aclr_q <= chk_bad;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            zone_q <= '0;
            zone_at_q <= 1'b0;
            fuse_q <= FUSE_RESET;
        end else begin
            if (zone_exec) begin
                zone_q <= a2_q;
                zone_at_q <= a1_q == SYS_ZONE_AT;
            end
            if (fuse_go) begin
                fuse_q[FUSE_FAB] <= fuse_q[FUSE_FAB] && a2_q != FUSE_ID_FAB;
                fuse_q[FUSE_ISSUER] <= fuse_q[FUSE_ISSUER] && a2_q != FUSE_ID_ISSUER;
                fuse_q[FUSE_PERS] <= fuse_q[FUSE_PERS] && a2_q != FUSE_ID_PERS;
                fuse_q[FUSE_LOT] <= fuse_q[FUSE_LOT] && a2_q != FUSE_ID_LOT;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cp_act_q <= 1'b0;
            cp_idx_q <= '0;
            wbase_q <= '0;
            wcfg_q <= 1'b0;
        end else if (do_commit) begin
            cp_act_q <= 1'b1;
            cp_idx_q <= '0;
            if (direct_commit) begin
                wbase_q <= hdr_addr;
                wcfg_q <= is_sys;
            end
        end else if (cp_act_q && fifo_ready) begin
            cp_idx_q <= cp_idx_q + 5'h01;
            cp_act_q <= !cp_last;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            at_q <= 1'b0;
            tmr_q <= '0;
        end else if (busy_go) begin
            busy_q <= 1'b1;
            at_q <= at_sel;
            tmr_q <= at_sel ? TMR_W'(WRITE_AT_CYC) : TMR_W'(WRITE_CYC);
        end else if (busy_q && !cp_act_q) begin
            tmr_q <= tmr_q - TMR_W'(1);
            busy_q <= tmr_q != TMR_W'(1);
        end
    end

    byte_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(cp_act_q),
        .in_data({wcfg_q, wbase_q + {11'h000, cp_idx_q}, wbuf_q[cp_idx_q[3:0]]}),
        .in_ready(fifo_ready),
        .out_valid(mem_wr_valid),
        .out_data({mem_wr_cfg, mem_wr_addr, mem_wr_data}),
        .out_ready(mem_wr_ready)
    );

    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign rd_addr = ptr_q;
    assign rd_cfg = ptr_cfg_q;
    assign zone_sel = zone_q;
    assign anti_tear = zone_at_q;
    assign fuse_state = fuse_q;
    assign checksum_word = chk_q;
    assign crypto_reset = crst_q;
    assign auth_clear = aclr_q;
    assign busy = busy_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_busy_nack: assert property (@(posedge mclk) disable iff (!rstn)
        byte_done && state_q == st_cmd && busy_q |=> !sda_oe) else $error("ack while busy");
    a_fixed_addr: assert property (@(posedge mclk) disable iff (!rstn)
        byte_done && state_q == st_cmd && sh_q[7:4] == DEV_ADDR_FIXED && !busy_q
        |=> sda_oe && ackph_q) else $error("fixed address not acked");
    a_alt_addr: assert property (@(posedge mclk) disable iff (!rstn)
        byte_done && state_q == st_cmd && sh_q[7:4] != DEV_ADDR_FIXED &&
        sh_q[7:4] != device_config_byte[3:0] |=> !sda_oe) else $error("foreign address acked");
    a_wr_perm: assert property (@(posedge mclk) disable iff (!rstn)
        byte_done && state_q == st_cnt && is_user_wr && !zone_wr_allowed
        |=> !sda_oe && state_q == st_ignore) else $error("write count acked");
    a_rd_perm: assert property (@(posedge mclk) disable iff (!rstn)
        byte_done && state_q == st_cnt && op_q == OP_READ_USER && !zone_rd_allowed
        |=> !sda_oe ##1 !tx_q) else $error("read count acked");
    a_fuse_down: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(fuse_q) |-> (fuse_q & ~$past(fuse_q)) == 4'h0 && $past(secure_code_ok))
        else $error("fuse rose or no secure code");
    a_fuse_order: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(fuse_q[FUSE_PERS]) |-> !fuse_q[FUSE_ISSUER] && !fuse_q[FUSE_FAB])
        else $error("fuse blown out of order");
    a_bad_chk: assert property (@(posedge mclk) disable iff (!rstn)
        chk_bad |=> auth_clear ##1 !auth_clear) else $error("privilege not cleared");
    a_zone_at: assert property (@(posedge mclk) disable iff (!rstn)
        zone_exec |=> anti_tear == $past(a1_q == SYS_ZONE_AT) && zone_sel == $past(a2_q))
        else $error("zone select wrong");
    a_ptr_wrap: assert property (@(posedge mclk) disable iff (!rstn)
        ptr_step && !ptr_cfg_q && ptr_q == zone_last |=> rd_addr == 16'h0000)
        else $error("pointer did not wrap");
    a_hold_data: assert property (@(posedge mclk) disable iff (!rstn)
        hold |=> pend_q && !cp_act_q && !busy_q) else $error("crypto write not held");
endmodule : twi_cmd_core

/* test/twi_host_model.sv */
`timescale 1ns/100ps
module twi_host_model (
    output logic scl,
    output logic sda,
    input wire logic sda_oe
);
    logic pull_q = 1'b0;
    initial scl = 1'b1;
    ////////////////////////////////////////////////////////////////
    // pulled up: high unless a party pulls low; clock idles high between frames
    assign sda = !(pull_q || sda_oe);
    task automatic clk_bit(input logic b, output logic s);
        #40 pull_q = !b;
        #60 scl = 1'b1;
        #90 s = sda;
        #10 scl = 1'b0;
    endtask : clk_bit
    // start condition when stop is low, stop condition when high
    task automatic cond(input logic stop);
        #40 pull_q = stop;
        #60 scl = 1'b1;
        #50 pull_q = !stop;
        #50 scl = stop;
    endtask : cond
    task automatic xfer(input logic [7:0] tx, input logic give_ack, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(!give_ack, ack);
        ack = !ack;
    endtask : xfer
endmodule : twi_host_model

/* test/test_secure_eeprom_twi_commands.sv */
`timescale 1ns/100ps
module test_secure_eeprom_twi_commands;
    import twi_cmd_pkg::*;
    typedef struct packed {logic [7:0] cmd; logic [7:0] cfg; logic ack;} row_type;
    row_type rows[6] = '{'{8'hB4, 8'hFF, 1'b1}, '{8'hF4, 8'hFF, 1'b1}, '{8'h34, 8'hFF, 1'b0},
        '{8'h34, 8'hF3, 1'b1}, '{8'hF4, 8'hF3, 1'b0}, '{8'hB4, 8'hF3, 1'b1}};
    logic [7:0] fid[4] = '{FUSE_ID_ISSUER, FUSE_ID_FAB, FUSE_ID_ISSUER, FUSE_ID_PERS};
    logic [3:0] fexp[4] = '{4'h7, 4'h6, 4'h4, 4'h4};
    logic rstn = 1'b0, wr_ok = 1'b1, rd_ok = 1'b1, sec_ok = 1'b0, sum_ok = 1'b1, rdy = 1'b1;
    logic auth_seen = 1'b0, mclk, scl, sda, oe, ack, dack, wv, busy, at, auth;
    logic crypto = 1'b0, crst_seen = 1'b0, sdo, rcfg, mcfg, crst;
    logic [7:0] dcfg = 8'hFF, zone, rx, wd, lo = 8'h10, hi = 8'h1F;
    logic [15:0] zl = 16'h00FF, ra, wa, chk;
    logic [3:0] fuses;
    logic [24:0] words[$];
    int errors = 0, total_checks = 0, cycles = 0;
    wire logic [7:0] rd_data = ra[7:0] ^ 8'h5A;
    twi_cmd_core #(.WRITE_CYC(20), .WRITE_AT_CYC(40)) dut_u (.mclk(mclk), .rstn(rstn),
        .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(oe), .device_config_byte(dcfg),
        .zone_wr_allowed(wr_ok), .zone_rd_allowed(rd_ok), .zone_crypto_write(crypto),
        .secure_code_ok(sec_ok), .checksum_ok(sum_ok), .cfg_auth_lo(lo), .cfg_auth_hi(hi),
        .zone_last(zl), .rd_addr(ra), .rd_cfg(rcfg), .rd_data(rd_data), .mem_wr_valid(wv),
        .mem_wr_ready(rdy), .mem_wr_addr(wa), .mem_wr_data(wd), .mem_wr_cfg(mcfg),
        .zone_sel(zone), .anti_tear(at), .fuse_state(fuses), .checksum_word(chk),
        .crypto_reset(crst), .auth_clear(auth), .busy(busy));
    twi_host_model host_u (.scl(scl), .sda(sda), .sda_oe(oe));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = !mclk;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles++;
        if (wv && rdy) words.push_back({mcfg, wa, wd});
        if (auth) auth_seen = 1'b1;
        if (crst) crst_seen = 1'b1;
        if (cycles == 40000) begin
            errors++;
            wrap_up();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task frame(input logic [31:0] h, input int n);
        host_u.cond(1'b0);
        for (int i = 3; i >= 0; i--) host_u.xfer(h[i*8+:8], 1'b0, rx, ack);
        for (int i = 0; i < n; i++) host_u.xfer(8'hC0 + i[7:0], 1'b0, rx, dack);
    endtask : frame
    // stop, then wait out the internal write cycle
    task done;
        host_u.cond(1'b1);
        settle();
    endtask : done
    task settle;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge mclk);
        #2;
    endtask : settle
    task wrap_up;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge mclk);
        #2 rstn = 1'b1;
        check({fuses, sdo}, {4'h7, 1'b0});
        foreach (rows[i]) begin
            @(posedge mclk) #2 dcfg = rows[i].cfg;
            host_u.cond(1'b0);
            host_u.xfer(rows[i].cmd, 1'b0, rx, ack);
            host_u.cond(1'b1);
            check(ack, rows[i].ack);
        end
        @(posedge mclk) #2 dcfg = 8'hFF;
        frame({8'hB4, SYS_ZONE_AT, 8'h05, 8'h00}, 0);
        done();
        check({zone, at}, {8'h05, 1'b1});
        frame({8'hB4, SYS_ZONE, 8'h05, 8'h00}, 0);
        done();
        check({zone, at}, {8'h05, 1'b0});
        @(posedge mclk) #2 rdy = 1'b0;
        frame({8'hB0, 8'h00, 8'h00, 8'h10}, 16);
        check(ack, 1'b1);
        host_u.cond(1'b1);
        repeat (8) @(posedge mclk);
        host_u.cond(1'b0);
        host_u.xfer(8'hB2, 1'b0, rx, ack);
        check(ack, 1'b0);
        @(posedge mclk) #2 rdy = 1'b1;
        done();
        check(24'(words.size()), 24'd16);
        check(words[15], {1'b0, 16'h000F, 8'hCF});
        frame({8'hB0, 8'h00, 8'h00, 8'h11}, 0);
        check(ack, 1'b0);
        done();
        frame({8'hB4, SYS_CFG, 8'h18, 8'h0C}, 12);
        done();
        check(24'(words.size()), 24'd16);
        @(posedge mclk) #2 hi = 8'h19;
        frame({8'hB4, SYS_CFG_AT, 8'h18, 8'h02}, 2);
        host_u.cond(1'b1);
        repeat (30) @(posedge mclk);
        #2 check(busy, 1'b1);
        settle();
        check(words[17], {1'b1, 16'h0019, 8'hC1});
        check(rcfg, 1'b1);
        @(posedge mclk) #2 zl = 16'h0011;
        frame({8'hB2, 8'h00, 8'h10, 8'h03}, 0);
        for (int i = 0; i < 3; i++) begin
            host_u.xfer(8'hFF, i < 2, rx, ack);
            check(rx, (i == 2) ? 8'h5A : 8'h4A + i[7:0]);
        end
        done();
        frame({8'hB0, 8'h00, 8'h05, 8'h01}, 0);
        host_u.cond(1'b0);
        host_u.xfer(8'hB1, 1'b0, rx, ack);
        for (int i = 0; i < 2; i++) begin
            host_u.xfer(8'hFF, i == 0, rx, ack);
            check(rx, (i == 0) ? 8'h5F : 8'h5C);
        end
        done();
        @(posedge mclk) #2 rd_ok = 1'b0;
        frame({8'hB2, 8'h00, 8'h10, 8'h01}, 0);
        check(ack, 1'b0);
        done();
        wr_ok = 1'b0;
        frame({8'hB0, 8'h00, 8'h00, 8'h01}, 0);
        check(ack, 1'b0);
        done();
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) #2 sec_ok = (i < 3);
            frame({8'hB4, SYS_FUSE, fid[i], 8'h00}, 0);
            done();
            check(fuses, fexp[i]);
        end
        wr_ok = 1'b1;
        crypto = 1'b1;
        frame({8'hB0, 8'h00, 8'h20, 8'h02}, 2);
        done();
        sum_ok = 1'b0;
        frame({8'hB4, SYS_CHECKSUM, 8'h00, 8'h02}, 2);
        done();
        check(auth_seen, 1'b1);
        check({crst_seen, chk}, {1'b1, 16'hC0C1});
        check(24'(words.size()), 24'd18);
        rstn = 1'b0;
        #25 check({fuses, zone, busy}, {4'h7, 8'h00, 1'b0});
        rstn = 1'b1;
        repeat (2) @(posedge mclk);
        wrap_up();
    end
endmodule : test_secure_eeprom_twi_commands
